//--- rtl/osc_ctl_pkg.sv
// Constants for the internal oscillator control block
//------------------------------------------------------------
// Notes on behaviour
//------------------------------------------------------------
package osc_ctl_pkg;

  // Register indices; byte address is four times the index
  localparam logic [15:0] IDX_CURRENT_SOURCE = 16'h088E;
  localparam logic [15:0] IDX_READY_STATUS = 16'h0890;
  localparam logic [15:0] IDX_FORCE_ENABLE = 16'h0891;
  localparam logic [15:0] IDX_FREQ_TRIM = 16'h0892;
  localparam logic [15:0] IDX_FREQ_SELECT = 16'h0893;

  // Oscillator slots inside per-oscillator vectors
  localparam int OSC_HF = 0;
  localparam int OSC_MF = 1;
  localparam int OSC_LF = 2;
  localparam int OSC_CONV = 3;
  localparam int NUM_OSC = 4;

  // Bit positions in status and enable registers, and the source field LSB
  localparam int BIT_HF = 6;
  localparam int BIT_MF = 5;
  localparam int BIT_LF = 4;
  localparam int BIT_CONV = 2;
  localparam int BIT_FIXED = 1;
  localparam int SRC_LSB = 4;

  // Values after reset
  localparam logic [3:0] FORCE_RESET = 4'h0;
  localparam logic [2:0] FSEL_RESET = 3'h0;
  localparam logic [5:0] TRIM_RESET = 6'h00;

  // Current source codes
  localparam logic [1:0] SRC_HF = 2'h0;
  localparam logic [1:0] SRC_LF = 2'h1;

  // Settling times and their cycle counts at 50 ns
  localparam int CLK_PERIOD_NS = 50;
  localparam int HF_SETTLE_NS = 2000;
  localparam int MF_SETTLE_NS = 2000;
  localparam int LF_SETTLE_NS = 100000;
  localparam int CONV_SETTLE_NS = 20000;
  localparam int HF_SETTLE_CYC = (HF_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MF_SETTLE_CYC = (MF_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LF_SETTLE_CYC = (LF_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CONV_SETTLE_CYC = (CONV_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [NUM_OSC-1:0][15:0] SETTLE_CYC = {
    16'(CONV_SETTLE_CYC), 16'(LF_SETTLE_CYC), 16'(MF_SETTLE_CYC), 16'(HF_SETTLE_CYC)};

  // Half period of the modelled high clock per select code
  localparam logic [7:0][5:0] HF_HALF_CYC = {
    6'h01, 6'h01, 6'h01, 6'h02, 6'h04, 6'h08, 6'h10, 6'h20};

  // Cycles before the reset source strap is taken
  localparam logic [1:0] STRAP_WAIT = 2'h2;

endpackage : osc_ctl_pkg

//--- rtl/osc_ctl.sv
// Internal oscillator control and status with an AHB-Lite register slave
`timescale 1ns/10ps
module osc_ctl (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic hf_periph_req,
  input wire logic mf_periph_req,
  input wire logic lf_periph_req,
  input wire logic conv_rc_periph_req,
  input wire logic fixed_freq_periph_req,
  input wire logic [1:0] reset_source_config,
  output logic hf_run,
  output logic mf_run,
  output logic lf_run,
  output logic conv_rc_run,
  output logic hf_ready_flag,
  output logic mf_ready_flag,
  output logic lf_ready_flag,
  output logic conv_rc_ready_flag,
  output logic fixed_freq_ready_flag,
  output logic high_freq_osc,
  output logic [2:0] freq_select_field,
  output logic [5:0] trim_offset_field,
  output logic [1:0] current_source_field
);

  //------------------------------------------------------------
  // State
  //------------------------------------------------------------
  localparam logic [2:0] SEL_NONE = 3'h0;
  localparam logic [2:0] SEL_SRC = 3'h1;
  localparam logic [2:0] SEL_STAT = 3'h2;
  localparam logic [2:0] SEL_FORCE = 3'h3;
  localparam logic [2:0] SEL_TRIM = 3'h4;
  localparam logic [2:0] SEL_FSEL = 3'h5;

  typedef struct packed {
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
    logic wr_pend;
    logic [2:0] wr_sel;
    logic [1:0] strap_s1;
    logic [1:0] strap_s2;
    logic [1:0] strap_wait;
    logic strap_taken;
    logic [1:0] src;
    logic [4:0] req_s1;
    logic [4:0] req_s2;
    logic [osc_ctl_pkg::NUM_OSC-1:0] force_on;
    logic [2:0] fsel;
    logic [5:0] trim;
    logic [osc_ctl_pkg::NUM_OSC-1:0] run;
    logic [osc_ctl_pkg::NUM_OSC-1:0] ready;
    logic [osc_ctl_pkg::NUM_OSC-1:0][15:0] cnt;
    logic fixed_ready;
    logic [5:0] div_cnt;
    logic hf_clk;
  } state_t;

  localparam state_t ST_RESET = '{
    hreadyout: 1'b1,
    force_on: osc_ctl_pkg::FORCE_RESET,
    fsel: osc_ctl_pkg::FSEL_RESET,
    trim: osc_ctl_pkg::TRIM_RESET,
    default: '0
  };

  state_t st;
  state_t nx;

  //------------------------------------------------------------
  // Address decode
  //------------------------------------------------------------
  function automatic logic [31:0] reg_addr(input logic [15:0] idx);
    reg_addr = {14'h0000, idx, 2'b00};
  endfunction : reg_addr

  function automatic logic [2:0] decode(input logic [31:0] a, input logic [2:0] sz);
    // Only whole-word accesses reach a register
    if (sz != 3'h2) begin
      decode = SEL_NONE;
    end else if (a == reg_addr(osc_ctl_pkg::IDX_CURRENT_SOURCE)) begin
      decode = SEL_SRC;
    end else if (a == reg_addr(osc_ctl_pkg::IDX_READY_STATUS)) begin
      decode = SEL_STAT;
    end else if (a == reg_addr(osc_ctl_pkg::IDX_FORCE_ENABLE)) begin
      decode = SEL_FORCE;
    end else if (a == reg_addr(osc_ctl_pkg::IDX_FREQ_TRIM)) begin
      decode = SEL_TRIM;
    end else if (a == reg_addr(osc_ctl_pkg::IDX_FREQ_SELECT)) begin
      decode = SEL_FSEL;
    end else begin
      decode = SEL_NONE;
    end
  endfunction : decode

  //------------------------------------------------------------
  // Next state
  //------------------------------------------------------------
  logic access;
  logic [2:0] sel;
  logic fsel_wr;
  logic [osc_ctl_pkg::NUM_OSC-1:0] sys_sel;
  logic [osc_ctl_pkg::NUM_OSC-1:0] extra_req;

  always_comb begin
    nx = st;
    nx.hreadyout = 1'b1;
    nx.hresp = 1'b0;
    access = hsel && htrans[1] && hready;
    sel = decode(haddr, hsize);
    fsel_wr = 1'b0;
    sys_sel = '0;
    extra_req = '0;

    // Peripheral requests and strap come from other logic: two flops
    nx.req_s1 = {fixed_freq_periph_req, conv_rc_periph_req, lf_periph_req, mf_periph_req,
      hf_periph_req};
    nx.req_s2 = st.req_s1;
    nx.strap_s1 = reset_source_config;
    nx.strap_s2 = st.strap_s1;

    // Strap taken once, after the synchroniser has filled
    if (!st.strap_taken) begin
      if (st.strap_wait == osc_ctl_pkg::STRAP_WAIT) begin
        nx.strap_taken = 1'b1;
        nx.src = st.strap_s2;
      end else begin
        nx.strap_wait = st.strap_wait + 2'h1;
      end
    end

    // Address phase: latch the target, prepare read data
    nx.wr_pend = access && hwrite;
    nx.wr_sel = access ? sel : SEL_NONE;
    nx.hrdata = '0;
    if (access && !hwrite) begin
      if (sel == SEL_SRC) begin
        nx.hrdata[osc_ctl_pkg::SRC_LSB +: 2] = st.src;
      end else if (sel == SEL_STAT) begin
        nx.hrdata[osc_ctl_pkg::BIT_HF] = st.ready[osc_ctl_pkg::OSC_HF];
        nx.hrdata[osc_ctl_pkg::BIT_MF] = st.ready[osc_ctl_pkg::OSC_MF];
        nx.hrdata[osc_ctl_pkg::BIT_LF] = st.ready[osc_ctl_pkg::OSC_LF];
        nx.hrdata[osc_ctl_pkg::BIT_CONV] = st.ready[osc_ctl_pkg::OSC_CONV];
        nx.hrdata[osc_ctl_pkg::BIT_FIXED] = st.fixed_ready;
      end else if (sel == SEL_FORCE) begin
        nx.hrdata[osc_ctl_pkg::BIT_HF] = st.force_on[osc_ctl_pkg::OSC_HF];
        nx.hrdata[osc_ctl_pkg::BIT_MF] = st.force_on[osc_ctl_pkg::OSC_MF];
        nx.hrdata[osc_ctl_pkg::BIT_LF] = st.force_on[osc_ctl_pkg::OSC_LF];
        nx.hrdata[osc_ctl_pkg::BIT_CONV] = st.force_on[osc_ctl_pkg::OSC_CONV];
      end else if (sel == SEL_TRIM) begin
        nx.hrdata[5:0] = st.trim;
      end else if (sel == SEL_FSEL) begin
        nx.hrdata[2:0] = st.fsel;
      end
    end

    // Data phase: writes land at the end of it
    if (st.wr_pend) begin
      case (st.wr_sel)
        SEL_FORCE: begin
          nx.force_on[osc_ctl_pkg::OSC_HF] = hwdata[osc_ctl_pkg::BIT_HF];
          nx.force_on[osc_ctl_pkg::OSC_MF] = hwdata[osc_ctl_pkg::BIT_MF];
          nx.force_on[osc_ctl_pkg::OSC_LF] = hwdata[osc_ctl_pkg::BIT_LF];
          nx.force_on[osc_ctl_pkg::OSC_CONV] = hwdata[osc_ctl_pkg::BIT_CONV];
        end
        SEL_TRIM: begin
          nx.trim = hwdata[5:0];
        end
        SEL_FSEL: begin
          nx.fsel = hwdata[2:0];
          fsel_wr = 1'b1;
        end
        default: begin
        end
      endcase
    end

    // Run enables; medium and fixed clocks are divided from the high one
    sys_sel[osc_ctl_pkg::OSC_HF] = st.strap_taken && (st.src == osc_ctl_pkg::SRC_HF);
    sys_sel[osc_ctl_pkg::OSC_LF] = st.strap_taken && (st.src == osc_ctl_pkg::SRC_LF);
    extra_req[osc_ctl_pkg::OSC_HF] = st.run[osc_ctl_pkg::OSC_MF] || st.req_s2[4];
    for (int i = 0; i < osc_ctl_pkg::NUM_OSC; i++) begin
      nx.run[i] = st.force_on[i] || st.req_s2[i] || sys_sel[i] || extra_req[i];
      // Ready drops in the same edge as run so the flag never outlives it
      if (!nx.run[i] || (i == osc_ctl_pkg::OSC_HF && fsel_wr)) begin
        nx.cnt[i] = '0;
        nx.ready[i] = 1'b0;
      end else if (st.cnt[i] >= osc_ctl_pkg::SETTLE_CYC[i] - 16'h0001) begin
        nx.ready[i] = 1'b1;
      end else begin
        nx.cnt[i] = st.cnt[i] + 16'h0001;
      end
    end
    nx.ready[osc_ctl_pkg::OSC_MF] = nx.ready[osc_ctl_pkg::OSC_MF] &&
      nx.ready[osc_ctl_pkg::OSC_HF];
    nx.fixed_ready = nx.ready[osc_ctl_pkg::OSC_HF];

    // Modelled high clock; stalls while not locked
    if (nx.ready[osc_ctl_pkg::OSC_HF] && st.ready[osc_ctl_pkg::OSC_HF]) begin
      if (st.div_cnt >= osc_ctl_pkg::HF_HALF_CYC[st.fsel] - 6'h01) begin
        nx.div_cnt = '0;
        nx.hf_clk = !st.hf_clk;
      end else begin
        nx.div_cnt = st.div_cnt + 6'h01;
      end
    end else begin
      nx.div_cnt = '0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st <= ST_RESET;
    end else begin
      st <= nx;
    end
  end

  //------------------------------------------------------------
  // Outputs
  //------------------------------------------------------------
  assign hreadyout = st.hreadyout;
  assign hresp = st.hresp;
  assign hrdata = st.hrdata;
  assign hf_run = st.run[osc_ctl_pkg::OSC_HF];
  assign mf_run = st.run[osc_ctl_pkg::OSC_MF];
  assign lf_run = st.run[osc_ctl_pkg::OSC_LF];
  assign conv_rc_run = st.run[osc_ctl_pkg::OSC_CONV];
  assign hf_ready_flag = st.ready[osc_ctl_pkg::OSC_HF];
  assign mf_ready_flag = st.ready[osc_ctl_pkg::OSC_MF];
  assign lf_ready_flag = st.ready[osc_ctl_pkg::OSC_LF];
  assign conv_rc_ready_flag = st.ready[osc_ctl_pkg::OSC_CONV];
  assign fixed_freq_ready_flag = st.fixed_ready;
  assign high_freq_osc = st.hf_clk;
  assign freq_select_field = st.fsel;
  assign trim_offset_field = st.trim;
  assign current_source_field = st.src;

  //------------------------------------------------------------
  // Checks
  //------------------------------------------------------------
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  logic fsel_wr_now;
  logic force_wr_now;
  assign fsel_wr_now = st.wr_pend && (st.wr_sel == SEL_FSEL);
  assign force_wr_now = st.wr_pend && (st.wr_sel == SEL_FORCE);

  property p_hf_ready;
    hf_ready_flag |-> hf_run;
  endproperty
  a_hf_ready: assert property (p_hf_ready) else $error("hf ready without run");

  property p_mf_ready;
    mf_ready_flag |-> (mf_run && hf_ready_flag);
  endproperty
  a_mf_ready: assert property (p_mf_ready) else $error("mf ready not usable");

  property p_lf_ready;
    $rose(lf_ready_flag) |-> $past(lf_run, 2) && lf_run;
  endproperty
  a_lf_ready: assert property (p_lf_ready) else $error("lf ready without settle");

  property p_conv_ready;
    !conv_rc_run |-> !conv_rc_ready_flag;
  endproperty
  a_conv_ready: assert property (p_conv_ready) else $error("conv ready while off");

  property p_fixed_ready;
    fixed_freq_ready_flag == hf_ready_flag;
  endproperty
  a_fixed_ready: assert property (p_fixed_ready) else $error("fixed ready mismatch");

  property p_hf_force;
    (force_wr_now && hwdata[osc_ctl_pkg::BIT_HF]) |=> ##1 hf_run;
  endproperty
  a_hf_force: assert property (p_hf_force) else $error("hf force not running");

  property p_mf_force;
    (force_wr_now && hwdata[osc_ctl_pkg::BIT_MF]) |=> ##1 mf_run ##1 hf_run;
  endproperty
  a_mf_force: assert property (p_mf_force) else $error("mf force not running");

  property p_lf_force;
    (force_wr_now && hwdata[osc_ctl_pkg::BIT_LF]) |=> ##1 lf_run;
  endproperty
  a_lf_force: assert property (p_lf_force) else $error("lf force not running");

  property p_conv_force;
    (force_wr_now && hwdata[osc_ctl_pkg::BIT_CONV]) |=> ##1 conv_rc_run;
  endproperty
  a_conv_force: assert property (p_conv_force) else $error("conv force not running");

  property p_fsel_store;
    fsel_wr_now |=> freq_select_field == $past(hwdata[2:0]);
  endproperty
  a_fsel_store: assert property (p_fsel_store) else $error("select not stored");

  property p_trim_store;
    (st.wr_pend && st.wr_sel == SEL_TRIM) |=> trim_offset_field == $past(hwdata[5:0]);
  endproperty
  a_trim_store: assert property (p_trim_store) else $error("trim not stored");

  property p_fsel_clear;
    fsel_wr_now |=> !hf_ready_flag ##1 !hf_ready_flag;
  endproperty
  a_fsel_clear: assert property (p_fsel_clear) else $error("hf ready not cleared");

  property p_fsel_stall;
    fsel_wr_now |=> $stable(high_freq_osc) [*8];
  endproperty
  a_fsel_stall: assert property (p_fsel_stall) else $error("hf clock moved on relock");

  property p_src_hold;
    st.strap_taken |=> $stable(current_source_field);
  endproperty
  a_src_hold: assert property (p_src_hold) else $error("current source changed");

  property p_req_run;
    $rose(st.req_s2[osc_ctl_pkg::OSC_LF]) |=> lf_run;
  endproperty
  a_req_run: assert property (p_req_run) else $error("request did not run lf");

  property p_bus_ok;
    hreadyout && !hresp;
  endproperty
  a_bus_ok: assert property (p_bus_ok) else $error("bus answer not okay");

  c_relock: cover property (fsel_wr_now ##[1:60] $rose(hf_ready_flag));
  c_mf_up: cover property ($rose(mf_ready_flag));
  c_conv_up: cover property ($rose(conv_rc_ready_flag));
  c_clk_toggle: cover property ($changed(high_freq_osc));

endmodule : osc_ctl

//--- bench/tb_top.sv
// Self-checking bench for the oscillator control block over AHB-Lite
`timescale 1ns/10ps
module tb_top;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans, reset_source_config, current_source_field;
  logic [2:0] hsize, freq_select_field;
  logic [5:0] trim_offset_field;
  logic [4:0] req;
  logic hf_run, mf_run, lf_run, conv_rc_run, high_freq_osc;
  logic hf_ready_flag, mf_ready_flag, lf_ready_flag, conv_rc_ready_flag, fixed_freq_ready_flag;
  logic [31:0] q;
  logic lvl, moved;
  int n, error_cnt, checked;
  logic [7:0] trims [4] = '{8'h1F, 8'h20, 8'hFF, 8'h00};
  // Expected runs {hf, mf, lf, conv} for request bits fixed, conv, lf, mf, hf
  logic [3:0] run_exp [5] = '{4'h8, 4'h1, 4'h2, 4'hC, 4'h8};
  localparam logic [31:0] A_SRC = {14'h0000, osc_ctl_pkg::IDX_CURRENT_SOURCE, 2'h0};
  localparam logic [31:0] A_STAT = {14'h0000, osc_ctl_pkg::IDX_READY_STATUS, 2'h0};
  localparam logic [31:0] A_FEN = {14'h0000, osc_ctl_pkg::IDX_FORCE_ENABLE, 2'h0};
  localparam logic [31:0] A_TRIM = {14'h0000, osc_ctl_pkg::IDX_FREQ_TRIM, 2'h0};
  localparam logic [31:0] A_FSEL = {14'h0000, osc_ctl_pkg::IDX_FREQ_SELECT, 2'h0};
  localparam logic [31:0] A_RES = {14'h0000, 16'h088F, 2'h0};

  // Single slave: its ready is the bus ready
  assign hready = hreadyout;

  osc_ctl u_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .hf_periph_req(req[4]), .mf_periph_req(req[3]), .lf_periph_req(req[2]),
    .conv_rc_periph_req(req[1]), .fixed_freq_periph_req(req[0]),
    .reset_source_config(reset_source_config), .hf_run(hf_run), .mf_run(mf_run),
    .lf_run(lf_run), .conv_rc_run(conv_rc_run), .hf_ready_flag(hf_ready_flag),
    .mf_ready_flag(mf_ready_flag), .lf_ready_flag(lf_ready_flag),
    .conv_rc_ready_flag(conv_rc_ready_flag), .fixed_freq_ready_flag(fixed_freq_ready_flag),
    .high_freq_osc(high_freq_osc), .freq_select_field(freq_select_field),
    .trim_offset_field(trim_offset_field), .current_source_field(current_source_field)
  );

  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end

  //------------------------------------------------------------
  // Reporting
  //------------------------------------------------------------
  task automatic results();
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : results

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  //------------------------------------------------------------
  // Bus cycles
  //------------------------------------------------------------
  // Outputs are flops, so values read just after an edge are the settled pre-edge ones
  task automatic wait_rdy();
    int k;
    k = 0;
    do begin
      @(posedge hclk);
      k++;
    end while (hready !== 1'b1 && k < 20);
    if (hready !== 1'b1) begin
      error_cnt++;
      $display("wrong value at %0t: bus never ready", $time);
      results();
    end
  endtask : wait_rdy

  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    hsize <= 3'h2;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    r = hrdata;
  endtask : bus

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask : wr

  task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp, input string what);
    logic [31:0] r;
    bus(1'b0, a, 32'h00000000, r);
    check(r, exp, what);
  endtask : rd_chk

  // Bounded poll: a settle that never ends counts once and stops the run
  task automatic poll(input logic [31:0] a, input logic [31:0] exp, input int lim);
    logic [31:0] r;
    int k;
    k = 0;
    do begin
      bus(1'b0, a, 32'h00000000, r);
      k++;
    end while (r !== exp && k < lim);
    check(r, exp, "polled register");
    if (r !== exp) results();
  endtask : poll

  //------------------------------------------------------------
  // Main sequence
  //------------------------------------------------------------
  initial begin
    hsel = 1'b0;
    haddr = 32'h00000000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h00000000;
    req = 5'h00;
    reset_source_config = 2'h2;
    hresetn = 1'b0;
    error_cnt = 0;
    checked = 0;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (4) @(posedge hclk);
    rd_chk(A_SRC, 32'h00000020, "source neither");
    rd_chk(A_STAT, 32'h00000000, "status reset");
    rd_chk(A_FEN, 32'h00000000, "force reset");
    rd_chk(A_TRIM, 32'h00000000, "trim reset");
    rd_chk(A_FSEL, 32'h00000000, "select reset");
    wr(A_STAT, 32'h000000FF);
    rd_chk(A_STAT, 32'h00000000, "status read only");
    wr(A_RES, 32'h000000FF);
    rd_chk(A_RES, 32'h00000000, "reserved place");
    $display("test reset_values done");

    wr(A_FEN, 32'h000000FF);
    repeat (2) @(posedge hclk);
    check({hf_run, mf_run, lf_run, conv_rc_run}, 4'hF, "forced runs");
    check(hf_ready_flag, 1'b0, "hf settling");
    rd_chk(A_FEN, 32'h00000074, "force bits");
    poll(A_STAT, 32'h00000076, 1500);
    check({hf_ready_flag, mf_ready_flag, lf_ready_flag, conv_rc_ready_flag,
      fixed_freq_ready_flag}, 5'h1F, "ready ports");
    $display("test force_enable done");

    foreach (trims[i]) begin
      wr(A_TRIM, {24'h000000, trims[i]});
      rd_chk(A_TRIM, {26'h0000000, trims[i][5:0]}, "trim");
      check(trim_offset_field, trims[i][5:0], "trim port");
    end
    $display("test trim done");

    // Reserved codes 6 and 7 included: they run at the fastest model rate
    for (int c = 0; c < 8; c++) begin
      wr(A_FSEL, 32'(c));
      @(posedge hclk);
      check(hf_ready_flag, 1'b0, "hf ready after select");
      check(freq_select_field, c[2:0], "select port");
      rd_chk(A_STAT, 32'h00000014, "status relocking");
      lvl = high_freq_osc;
      moved = 1'b0;
      n = 0;
      while (hf_ready_flag !== 1'b1 && n < 200) begin
        if (high_freq_osc !== lvl) moved = 1'b1;
        @(posedge hclk);
        n++;
      end
      check(moved, 1'b0, "clock frozen while relocking");
      check(hf_ready_flag, 1'b1, "hf relocked");
      if (hf_ready_flag !== 1'b1) results();
      for (int t = 0; t < 2; t++) begin
        lvl = high_freq_osc;
        n = 0;
        while (high_freq_osc === lvl && n < 100) begin
          @(posedge hclk);
          n++;
        end
      end
      check(n, 32'(osc_ctl_pkg::HF_HALF_CYC[c]), "half period");
      if (n >= 100) results();
      rd_chk(A_FSEL, 32'(c), "select readback");
    end
    $display("test frequency_select done");

    // Source strap is neither, so dropping the force stops every oscillator
    wr(A_FEN, 32'h00000000);
    poll(A_STAT, 32'h00000000, 20);
    check({hf_run, mf_run, lf_run, conv_rc_run}, 4'h0, "runs off");
    for (int i = 0; i < 5; i++) begin
      req <= 5'(1 << i);
      repeat (6) @(posedge hclk);
      check({hf_run, mf_run, lf_run, conv_rc_run}, run_exp[i], "request run");
      req <= 5'h00;
      repeat (6) @(posedge hclk);
    end
    req <= 5'h1F;
    poll(A_STAT, 32'h00000076, 1500);
    rd_chk(A_FEN, 32'h00000000, "requests leave force");
    req <= 5'h00;
    poll(A_STAT, 32'h00000000, 20);
    $display("test requests done");

    @(posedge hclk);
    hresetn <= 1'b0;
    reset_source_config <= 2'h1;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (6) @(posedge hclk);
    rd_chk(A_SRC, 32'h00000010, "source low");
    check({hf_run, lf_run, current_source_field}, 4'h5, "system source runs");
    poll(A_STAT, 32'h00000010, 1500);
    // High oscillator as system source: only it and the derived clock come up
    @(posedge hclk);
    hresetn <= 1'b0;
    reset_source_config <= 2'h0;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (6) @(posedge hclk);
    rd_chk(A_SRC, 32'h00000000, "source high");
    check({hf_run, lf_run, current_source_field}, 4'h8, "high source runs");
    poll(A_STAT, 32'h00000042, 100);
    $display("test source_strap done");
    results();
  end
endmodule : tb_top
